// file: design/bds_defines.svh
// constants for the brushless drive supervisor: widths, steps, timing counts
// assumes a 50 MHz system clock
`ifndef BDS_DEFINES_SVH
`define BDS_DEFINES_SVH

`define BDS_CLK_HZ          50000000
// lead angle: 32 steps of 1.875 deg, level quantised from a 10-bit code
`define BDS_LEAD_STEPS      32
`define BDS_LEAD_TOP        5'h1f
`define BDS_LEVEL_W         10
`define BDS_LEVEL_SHIFT     5
// full-scale level code (3.125 V) maps to step 31
`define BDS_LEVEL_FULL      10'h3e0
// duty in 1/1280 units: 0.078 % per ramp step, 2.5 % = 32 units
`define BDS_DUTY_W          11
`define BDS_DUTY_MAX        11'h500
`define BDS_DUTY_STEP       11'h001
`define BDS_DUTY_DIRECT     11'h020
// zero-command hold time for fault release
`define BDS_ZERO_HOLD_US    2000
`define BDS_ZERO_HOLD_CYC   (`BDS_ZERO_HOLD_US * (`BDS_CLK_HZ / 1000000))
// position frequency thresholds, period measured in clk cycles
`define BDS_REV_STOP_HZ     40
`define BDS_NODIR_HZ        200
`define BDS_PER_W           24
`define BDS_PER_40HZ        24'(`BDS_CLK_HZ / `BDS_REV_STOP_HZ)
`define BDS_PER_200HZ       24'(`BDS_CLK_HZ / `BDS_NODIR_HZ)
`define BDS_PER_SAT         24'hffffff

`endif

// file: design/bds_pkg.sv
// types for the brushless drive supervisor
// assumes bds_defines.svh is on the include path
package bds_pkg;
  // brake sequence states
  typedef enum logic [2:0] {
    BDS_RUN    = 3'b000,
    BDS_REV    = 3'b001,
    BDS_SHORT  = 3'b010,
    BDS_RETRY  = 3'b011,
    BDS_STOP   = 3'b100
  } bds_brake_t;
  // phase drive modes
  typedef enum logic [1:0] {
    BDS_DRV_NORMAL = 2'b00,
    BDS_DRV_REVERSE = 2'b01,
    BDS_DRV_SHORT  = 2'b10,
    BDS_DRV_OFF    = 2'b11
  } bds_drive_t;
endpackage : bds_pkg

// file: design/bds_sync.sv
// two-flop synchroniser for a vector of asynchronous inputs
// assumes inputs arrive from outside the clk_sys domain
`timescale 1ns/1ns
`default_nettype none
module bds_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : bds_sync
`default_nettype wire

// file: design/bds_supervisor.sv
// brushless drive supervisor: lead angle, duty ramp, braking, protection
// assumes pin flags and ticks are asynchronous and pass a two-flop sync
// Operation
// - external mode quantises level into 32 steps
// - level at full scale saturates at step 31
// - ramp duty 0.078 percent per period
// - difference up to 2.5 percent applied directly
// - zero command turns off, clears duty
// - brake high requests braking, low runs
// - brake while running reverses until 40 Hz
// - zero command, detection on: 40 Hz split
// - zero command, detection off: 200 Hz split
// - overvoltage flag selects 120-degree commutation
// - current limit cuts high side until PWM edge
// - any of six overcurrent flags latches Hi-Z
// - overcurrent clears after 2 ms zero command
// - thermal flag holds phases Hi-Z, auto-resume
// - undervoltage floats phases, pulse and lock outputs
// - external step used only when select zero
`timescale 1ns/1ns
`include "bds_defines.svh"
`default_nettype none
module bds_supervisor (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  // command side
  input  wire logic [`BDS_LEVEL_W-1:0]   lead_angle_level_in,
  input  wire logic                      lead_mode_select,
  input  wire logic [`BDS_DUTY_W-1:0]    speed_command_in,
  input  wire logic                      ramp_period_cap,
  input  wire logic                      pwm_cycle_tick,
  input  wire logic                      pwm_on_edge,
  input  wire logic                      brake_in,
  input  wire logic                      dir_detect_en,
  input  wire logic                      position_edge,
  // protection flags
  input  wire logic                      supply_monitor_in,
  input  wire logic                      current_limit,
  input  wire logic [5:0]                overcurrent_shutdown,
  input  wire logic                      thermal_shutdown,
  input  wire logic                      undervoltage,
  // motor side status in
  input  wire logic                      rotation_pulse_in,
  input  wire logic                      lock_flag_in,
  // outputs
  output logic [4:0]                     lead_step,
  output logic                           lead_external,
  output logic [`BDS_DUTY_W-1:0]         duty_out,
  output bds_pkg::bds_drive_t            drive_mode,
  output logic                           comm_120,
  output logic                           high_side_en,
  output logic                           phase_oe,
  output logic                           rotation_pulse_out,
  output logic                           rotation_pulse_oe,
  output logic                           lock_flag_out,
  output logic                           lock_flag_oe,
  output logic                           fault_latched
);
  import bds_pkg::*;

  localparam int NSYNC = 17;  // eleven single flags plus six overcurrent bits

  logic [NSYNC-1:0] pins_sync;
  logic [5:0] s_ocp;
  logic       s_sel, s_cap, s_pwm, s_on, s_brake, s_dir, s_pos, s_ovp, s_clim, s_tsd, s_uv;
  logic       cap_d, pwm_d, on_d, brake_d, pos_d;                 // last synced levels
  logic       cap_tick, pwm_tick, on_tick, brake_rise, pos_tick;  // one-cycle rising edges
  logic       cmd_zero, zero_held, running, clim_cut;
  logic [`BDS_DUTY_W-1:0] diff;
  logic [31:0] zero_cnt;
  logic [`BDS_PER_W-1:0] per_cnt;
  logic [`BDS_PER_W-1:0] period;
  bds_brake_t brake_state;
  bds_brake_t next_brake;

  // all asynchronous flags pass two flops
  bds_sync #(.WIDTH(NSYNC)) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({lead_mode_select, ramp_period_cap, pwm_cycle_tick, pwm_on_edge,
                brake_in, dir_detect_en, position_edge, supply_monitor_in,
                current_limit, overcurrent_shutdown, thermal_shutdown, undervoltage}),
    .sync_out (pins_sync)
  );
  assign {s_sel, s_cap, s_pwm, s_on, s_brake, s_dir, s_pos, s_ovp,
          s_clim, s_ocp, s_tsd, s_uv} = pins_sync;

  // edge history for tick and transition detection
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cap_d   <= 1'b0;
      pwm_d   <= 1'b0;
      on_d    <= 1'b0;
      brake_d <= 1'b0;
      pos_d   <= 1'b0;
    end
    else
    begin
      cap_d   <= s_cap;
      pwm_d   <= s_pwm;
      on_d    <= s_on;
      brake_d <= s_brake;
      pos_d   <= s_pos;
    end
  end
  assign cap_tick   = s_cap & ~cap_d;
  assign pwm_tick   = s_pwm & ~pwm_d;
  assign on_tick    = s_on & ~on_d;
  assign brake_rise = s_brake & ~brake_d;
  assign pos_tick   = s_pos & ~pos_d;
  assign cmd_zero   = (speed_command_in == '0);

  // lead angle step: level code / 32, saturating at full scale
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      lead_step     <= 5'h00;
      lead_external <= 1'b0;
    end
    else
    begin
      lead_external <= ~s_sel;
      if (lead_angle_level_in >= `BDS_LEVEL_FULL)
        lead_step <= `BDS_LEAD_TOP;
      else
        lead_step <= lead_angle_level_in[`BDS_LEVEL_W-1:`BDS_LEVEL_SHIFT];
    end
  end

  // duty ramp toward command; small steps applied per PWM cycle
  assign diff = (speed_command_in > duty_out) ? speed_command_in - duty_out
                                              : duty_out - speed_command_in;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      duty_out <= '0;
    else if (cmd_zero)
      duty_out <= '0;
    else if (diff <= `BDS_DUTY_DIRECT)
    begin
      if (pwm_tick)
        duty_out <= speed_command_in;
    end
    else if (cap_tick)
    begin
      if (speed_command_in > duty_out)
        duty_out <= duty_out + `BDS_DUTY_STEP;
      else
        duty_out <= duty_out - `BDS_DUTY_STEP;
    end
  end

  // zero-command hold timer for fault release
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      zero_cnt <= '0;
    else if (!cmd_zero)
      zero_cnt <= '0;
    else if (!zero_held)
      zero_cnt <= zero_cnt + 32'h1;
  end
  assign zero_held = (zero_cnt >= 32'(`BDS_ZERO_HOLD_CYC));

  // overcurrent latch: set wins over release
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      fault_latched <= 1'b0;
    else if (|s_ocp)
      fault_latched <= 1'b1;
    else if (zero_held)
      fault_latched <= 1'b0;
  end

  // position period measurement between edges
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      per_cnt <= '0;
      period  <= `BDS_PER_SAT;
    end
    else if (pos_tick)
    begin
      period  <= per_cnt;
      per_cnt <= '0;
    end
    else if (per_cnt != `BDS_PER_SAT)
    begin
      per_cnt <= per_cnt + 24'h1;
      if (per_cnt >= period)
        period <= per_cnt;                    // slowing motor stretches period
    end
  end
  assign running = (period < `BDS_PER_SAT);

  // brake sequence
  always_comb
  begin
    next_brake = brake_state;
    case (brake_state)
      BDS_RUN:
        if (brake_rise && running)
        begin
          if (!cmd_zero)
            next_brake = BDS_REV;
          else if (s_dir)
            next_brake = (period >= `BDS_PER_40HZ) ? BDS_SHORT : BDS_REV;
          else
            next_brake = (period >= `BDS_PER_200HZ) ? BDS_SHORT : BDS_RETRY;
        end
        else if (brake_rise)
          next_brake = BDS_SHORT;
      BDS_REV:
        if (!s_brake)
          next_brake = BDS_RUN;
        else if (period >= `BDS_PER_40HZ)
          next_brake = cmd_zero ? BDS_SHORT : BDS_STOP;
      BDS_RETRY:
        if (s_dir || period >= `BDS_PER_200HZ)
          next_brake = BDS_RUN;
      BDS_SHORT, BDS_STOP:
        if (!s_brake)
          next_brake = BDS_RUN;
      default:
        next_brake = BDS_RUN;
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      brake_state <= BDS_RUN;
    else
      brake_state <= next_brake;
  end

  // current limit cut until next PWM on-edge; trip wins
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      clim_cut <= 1'b0;
    else if (s_clim)
      clim_cut <= 1'b1;
    else if (on_tick)
      clim_cut <= 1'b0;
  end

  // output drive with fault priority
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      drive_mode         <= BDS_DRV_OFF;
      phase_oe           <= 1'b0;
      high_side_en       <= 1'b0;
      comm_120           <= 1'b0;
      rotation_pulse_out <= 1'b0;
      rotation_pulse_oe  <= 1'b0;
      lock_flag_out      <= 1'b0;
      lock_flag_oe       <= 1'b0;
    end
    else
    begin
      comm_120           <= s_ovp;
      rotation_pulse_out <= rotation_pulse_in;
      lock_flag_out      <= lock_flag_in;
      rotation_pulse_oe  <= ~s_uv;
      lock_flag_oe       <= ~s_uv;
      high_side_en       <= ~s_clim & ~clim_cut;
      if (s_uv || s_tsd || fault_latched || (|s_ocp))
      begin
        phase_oe   <= 1'b0;
        drive_mode <= BDS_DRV_OFF;
      end
      else
      begin
        phase_oe <= 1'b1;
        case (brake_state)
          BDS_REV:   drive_mode <= BDS_DRV_REVERSE;
          BDS_SHORT: drive_mode <= BDS_DRV_SHORT;
          BDS_STOP:  drive_mode <= BDS_DRV_OFF;
          default:   drive_mode <= cmd_zero ? BDS_DRV_OFF : BDS_DRV_NORMAL;
        endcase
      end
    end
  end
endmodule : bds_supervisor
`default_nettype wire

// file: dv/bds_supervisor_props.sv
// checker for the drive supervisor: protection, mode and duty relations
// assumes binding to bds_supervisor; flags pass 2 sync flops plus 1 register
`timescale 1ns/1ns
`include "bds_defines.svh"
`default_nettype none
module bds_supervisor_props (
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    rst,
  // watched inputs
  input wire logic [`BDS_LEVEL_W-1:0] lead_angle_level_in,
  input wire logic                    lead_mode_select,
  input wire logic [`BDS_DUTY_W-1:0]  speed_command_in,
  input wire logic                    supply_monitor_in,
  input wire logic                    current_limit,
  input wire logic [5:0]              overcurrent_shutdown,
  input wire logic                    thermal_shutdown,
  input wire logic                    undervoltage,
  // watched outputs
  input wire logic [4:0]              lead_step,
  input wire logic                    lead_external,
  input wire logic [`BDS_DUTY_W-1:0]  duty_out,
  input wire bds_pkg::bds_drive_t     drive_mode,
  input wire logic                    comm_120,
  input wire logic                    high_side_en,
  input wire logic                    phase_oe,
  input wire logic                    rotation_pulse_oe,
  input wire logic                    lock_flag_oe,
  input wire logic                    fault_latched
);
  import bds_pkg::*;
  // one clock domain for every check
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // protection
  a_ocp_float: assert property (|overcurrent_shutdown |-> ##[1:4] !phase_oe)
    else $error("overcurrent did not float the phases");
  a_ocp_latch: assert property (|overcurrent_shutdown |-> ##[1:4] fault_latched)
    else $error("overcurrent did not latch");
  a_thermal_float: assert property (thermal_shutdown[*4] |-> !phase_oe)
    else $error("thermal flag left phases driven");
  a_uv_float: assert property (undervoltage[*4] |->
    !(phase_oe | rotation_pulse_oe | lock_flag_oe))
    else $error("undervoltage left an output driven");
  a_limit_cut: assert property (current_limit[*4] |-> !high_side_en)
    else $error("current limit left high side on");
  // commutation mode
  a_ov_select: assert property (supply_monitor_in[*4] |-> comm_120)
    else $error("overvoltage without 120 degree mode");
  a_ov_return: assert property ((!supply_monitor_in)[*4] |-> !comm_120)
    else $error("120 degree mode without overvoltage");
  // duty and lead angle
  a_zero_duty: assert property (speed_command_in == '0 |-> ##[1:2] duty_out == '0)
    else $error("zero command did not clear duty");
  a_lead_follow: assert property ((!lead_mode_select && $stable(lead_angle_level_in))[*5]
    |-> lead_external && lead_step == lead_angle_level_in[9:5])
    else $error("lead step does not follow level");
  // main scenarios reached
  c_latched: cover property (fault_latched);
  c_reverse: cover property (drive_mode == BDS_DRV_REVERSE);
  c_mode120: cover property (comm_120);
endmodule : bds_supervisor_props
bind bds_supervisor bds_supervisor_props u_props (.clk_sys, .rst, .lead_angle_level_in,
  .lead_mode_select, .speed_command_in, .supply_monitor_in, .current_limit,
  .overcurrent_shutdown, .thermal_shutdown, .undervoltage, .lead_step, .lead_external,
  .duty_out, .drive_mode, .comm_120, .high_side_en, .phase_oe, .rotation_pulse_oe,
  .lock_flag_oe, .fault_latched);
`default_nettype wire

// file: dv/bds_motor_model.sv
// motor and power stage model: position edges, rotation pulse, lock flag
// assumes period in clk cycles; zero period means the rotor stands still
`timescale 1ns/1ns
`default_nettype none
module bds_motor_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // rotation speed
  input  wire logic [23:0] period,
  // sensor outputs
  output var logic         position_edge,
  output var logic         rotation_pulse_in,
  output var logic         lock_flag_in
);
  logic [23:0] cnt;
  // position edge two cycles wide once each period, none when stopped
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt           <= '0;
      position_edge <= 1'b0;
    end
    else if (period == '0)
    begin
      cnt           <= '0;    // rotor stands still
      position_edge <= 1'b0;
    end
    else
    begin
      cnt <= (cnt >= period - 24'h1) ? '0 : cnt + 24'h1;
      position_edge <= (cnt < 24'h2);
    end
  end
  // rotation pulse toggles per edge; lock flag shows a still rotor
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rotation_pulse_in <= 1'b0;
    else if (cnt == 24'h1)
      rotation_pulse_in <= ~rotation_pulse_in;
  end
  assign lock_flag_in = (period == '0);
endmodule : bds_motor_model
`default_nettype wire

// file: dv/tb_bds_drive_supervisor.sv
// testbench for the drive supervisor: random and corner stimulus
// assumes a 50 MHz clock and the motor model on the position inputs
`timescale 1ns/1ns
`default_nettype none
module tb_bldc_drive_supervisor;
  import bds_pkg::*;
  logic clk_sys = 0, rst = 1, lead_mode_select = 0, ramp_period_cap = 0;
  logic pwm_cycle_tick = 0, pwm_on_edge = 0, brake_in = 0, dir_detect_en = 0;
  logic supply_monitor_in = 0, current_limit = 0, thermal_shutdown = 0, undervoltage = 0;
  logic [9:0] lead_angle_level_in = '0;
  logic [10:0] speed_command_in = '0;
  logic [5:0] overcurrent_shutdown = '0;
  logic [23:0] period = '0;
  logic position_edge, rotation_pulse_in, lock_flag_in, lead_external, comm_120;
  logic high_side_en, phase_oe, rotation_pulse_out, rotation_pulse_oe;
  logic lock_flag_out, lock_flag_oe, fault_latched;
  logic [4:0] lead_step;
  logic [10:0] duty_out;
  bds_drive_t drive_mode;
  logic [15:0] r = 16'h002b;
  int n_mismatch = 0, compares = 0;
  // device and far side
  bds_supervisor dut_u (.clk_sys, .rst, .lead_angle_level_in, .lead_mode_select,
    .speed_command_in, .ramp_period_cap, .pwm_cycle_tick, .pwm_on_edge, .brake_in,
    .dir_detect_en, .position_edge, .supply_monitor_in, .current_limit,
    .overcurrent_shutdown, .thermal_shutdown, .undervoltage, .rotation_pulse_in,
    .lock_flag_in, .lead_step, .lead_external, .duty_out, .drive_mode, .comm_120,
    .high_side_en, .phase_oe, .rotation_pulse_out, .rotation_pulse_oe, .lock_flag_out,
    .lock_flag_oe, .fault_latched);
  bds_motor_model motor_u (.clk_sys, .rst, .period, .position_edge, .rotation_pulse_in,
    .lock_flag_in);
  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;
  // next random value
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  // expected step: top five bits of the level code
  function automatic logic [4:0] exp_step(input logic [9:0] lv);
    return lv[9:5];
  endfunction : exp_step
  // wait n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  // two-cycle pulse, then let the sync and edge detect settle
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(2);
    s = 1'b0;
    tick(5);
  endtask : pulse
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    compares++;
    if (e !== g)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // cut a hang short
  initial
  begin
    #(120000 * 20);
    n_mismatch++;
    give_verdict();
  end
  // test sequence
  initial
  begin
    tick(8);
    rst = 0;
    tick(1);
    for (int i = 0; i < 10; i++)
    begin
      r = lfsr(r);
      lead_angle_level_in = (i == 0) ? 10'h3ff : (i == 1) ? 10'h3e0 : r[9:0];
      tick(6);
      chk("lead_step", 11'(exp_step(lead_angle_level_in)), 11'(lead_step));
    end
    lead_mode_select = 1;
    tick(5);
    chk("lead_external", 11'h0, 11'(lead_external));
    $display("test lead done");
    speed_command_in = 11'h014;
    pulse(pwm_cycle_tick);
    chk("duty direct", 11'h014, duty_out);
    r = lfsr(r);
    speed_command_in = 11'h014 + 11'(r[4:0]);
    pulse(pwm_cycle_tick);
    chk("duty random", speed_command_in, duty_out);
    speed_command_in = duty_out + 11'h064;
    repeat (3) pulse(ramp_period_cap);
    chk("duty ramp", speed_command_in - 11'h061, duty_out);
    $display("test duty done");
    r = lfsr(r);
    overcurrent_shutdown = 6'h01 << (r % 6);
    tick(4);
    overcurrent_shutdown = '0;
    tick(20);
    chk("ocp", 11'h2, {9'h0, fault_latched, phase_oe});
    speed_command_in = '0;
    tick(2);
    chk("duty zero", 11'h0, duty_out);
    tick(99000);
    chk("ocp held", 11'h1, 11'(fault_latched));
    tick(1100);
    chk("ocp clear", 11'h1, {9'h0, fault_latched, phase_oe});
    $display("test overcurrent done");
    thermal_shutdown = 1;
    tick(4);
    chk("thermal on", 11'h0, 11'(phase_oe));
    thermal_shutdown = 0;
    tick(4);
    chk("thermal off", 11'h1, 11'(phase_oe));
    undervoltage = 1;
    tick(4);
    chk("uv on", 11'h0, {8'h0, phase_oe, rotation_pulse_oe, lock_flag_oe});
    undervoltage = 0;
    tick(4);
    chk("uv off", 11'h7, {8'h0, phase_oe, rotation_pulse_oe, lock_flag_oe});
    chk("lock still", 11'h1, 11'(lock_flag_out));
    supply_monitor_in = 1;
    tick(4);
    chk("mode 120", 11'h1, 11'(comm_120));
    supply_monitor_in = 0;
    tick(4);
    chk("mode 150", 11'h0, 11'(comm_120));
    current_limit = 1;
    tick(4);
    current_limit = 0;
    tick(6);
    chk("limit cut", 11'h0, 11'(high_side_en));
    pulse(pwm_on_edge);
    chk("limit on edge", 11'h1, 11'(high_side_en));
    $display("test protection done");
    brake_in = 1;
    tick(5);
    chk("brake still", 11'(BDS_DRV_SHORT), 11'(drive_mode));
    brake_in = 0;
    dir_detect_en = r[0];
    speed_command_in = 11'h040;
    period = 24'd1000;
    tick(3000);
    brake_in = 1;
    tick(5);
    chk("brake run", 11'(BDS_DRV_REVERSE), 11'(drive_mode));
    brake_in = 0;
    tick(5);
    chk("brake off", 11'(BDS_DRV_NORMAL), 11'(drive_mode));
    speed_command_in = '0;
    dir_detect_en = 1;
    tick(5);
    brake_in = 1;
    tick(5);
    chk("brake zero", 11'(BDS_DRV_REVERSE), 11'(drive_mode));
    chk("pulse pass", 11'(rotation_pulse_in), 11'(rotation_pulse_out));
    chk("lock pass", 11'h0, 11'(lock_flag_out));
    brake_in = 0;
    tick(5);
    chk("brake zero off", 11'(BDS_DRV_OFF), 11'(drive_mode));
    $display("test brake done");
    give_verdict();
  end
endmodule : tb_bldc_drive_supervisor
`default_nettype wire
